/* logic/dsm_consts.svh */
// Purpose: Offsets, fields, reset values and timing counts of the motion monitor
// Assumes: 50 MHz system clock
// Notes: Byte addresses on the Wishbone slave, one 32-bit word each; DSM_ADR_LIMIT_HI is the upper address nibble of the four limit words
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH

`define DSM_ADR_CTRL 8'h00
`define DSM_ADR_STOP_DELAY 8'h04
`define DSM_ADR_STOP_SPEED 8'h08
`define DSM_ADR_DECEL_STEP 8'h0c
`define DSM_ADR_LIMIT_HI 4'h1
`define DSM_ADR_WINDOW 8'h20
`define DSM_ADR_STATUS 8'h24

`define DSM_CTRL_EXT 0
`define DSM_CTRL_NEG 1
`define DSM_CTRL_RAMP 2
`define DSM_CTRL_ACK 3

`define DSM_STOP_DELAY_RST 24'h00c350
`define DSM_STOP_SPEED_RST 16'h0010
`define DSM_DECEL_STEP_RST 16'h0010
`define DSM_LIMIT_RST 16'h0100
`define DSM_WINDOW_RST 24'h00c350

`define DSM_CLK_PERIOD_NS 20
`define DSM_RAMP_TICK_NS 1000
`define DSM_RAMP_TICK_CYC ((`DSM_RAMP_TICK_NS + `DSM_CLK_PERIOD_NS - 1) / `DSM_CLK_PERIOD_NS)
`define DSM_PIN_CNT 3

`endif

/* logic/dsm_motion_monitor.sv */
// Purpose: Controlled stop, limited speed and direction guard for a drive
// Assumes: Speed and setpoint come from logic on clk_sys; select pins are async
// Notes: Wishbone classic slave holds the configuration
// Functional notes
// - Controlled stop drives setpoint to zero to remove kinetic energy.
// - Extended stop supervises deceleration, removes torque below speed threshold.
// - Basic stop removes torque when the delay timer started at selection expires.
// - Limited speed requested by pin or telegram, either one suffices.
// - Limited speed clamps setpoint below the selected limit.
// - Overspeed at limited-speed selection brakes on the fast-stop ramp.
// - Speed may come down within a time window or braking ramp first.
// - Speed magnitude, sign ignored, is compared with the selected limit.
// - Limited speed in force is reported on a status output.
// - Overspeed while limit in force triggers the safe-stop reaction.
// - Four limit levels, each with its own value, one active.
// - Level selects come from outside; active level is reported back.
// - Level choice only from telegram; pin request uses level zero.
// - Direction guard requested by pin or telegram, either one suffices.
// - Direction guard restricts setpoint to the permitted direction.
// - Inhibited motion at selection brakes on fast-stop ramp within time or ramp.
// - Direction guard monitors speed sign and reports guard in force.
// - Inhibited motion while guard in force triggers the safe-stop reaction.
// - Torque removal cuts torque-producing energy; motor coasts.
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "dsm_consts.svh"
module dsm_motion_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic stopSelPin,
  input wire logic speedSelPin,
  input wire logic dirSelPin,
  input wire logic tgStopSel,
  input wire logic tgSpeedSel,
  input wire logic [1:0] tgLevel,
  input wire logic tgDirSel,
  input wire logic tgAck,
  input wire dsm_pkg::dsm_speed_t actualSpeed,
  input wire dsm_pkg::dsm_speed_t setpointIn,
  output dsm_pkg::dsm_speed_t setpointOut,
  output logic fastStopRamp,
  output logic torqueRemoval,
  output logic stopActive,
  output logic limitActive,
  output logic [1:0] levelActive,
  output logic dirActive,
  output logic safeStopLatched
);
  import dsm_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic ctrlExt;
    logic ctrlNeg;
    logic ctrlRamp;
    logic ackPulse;
    logic [23:0] stopDelay;
    logic [15:0] stopSpeed;
    logic [15:0] decelStep;
    logic [3:0][15:0] limits;
    logic [23:0] window;
    dsm_stop_st_t st;
    dsm_phase_t limPh;
    dsm_phase_t dirPh;
    logic [1:0] level;
    logic [23:0] stopTmr;
    logic [23:0] limTmr;
    logic [23:0] dirTmr;
    logic [15:0] env;
    logic [15:0] dirEnv;
    logic [5:0] tick;
    dsm_speed_t spOut;
    logic fastRamp;
    logic toff;
    logic stopAct;
    logic limAct;
    logic [1:0] lvlOut;
    logic dirAct;
    logic latched;
  } dsm_state_t;

  dsm_state_t s_r;
  dsm_state_t s_nxt;
  logic [`DSM_PIN_CNT-1:0] pinSync;
  logic stopReq;
  logic limReq;
  logic dirReq;
  logic [1:0] selLevel;
  logic [15:0] absSpd;
  logic [15:0] curLim;
  logic inhib;

  function automatic logic [15:0] dsmAbs(input dsm_speed_t v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction : dsmAbs

  function automatic logic [31:0] wrMerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : wrMerge

  function automatic logic [15:0] decay(input logic [15:0] e, input logic [15:0] step);
    return (e > step) ? 16'(e - step) : 16'h0000;
  endfunction : decay

  dsm_pin_sync u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pinAsync({dirSelPin, speedSelPin, stopSelPin}),
    .pinSync(pinSync)
  );

  assign stopReq = pinSync[0] | tgStopSel;
  assign limReq = pinSync[1] | tgSpeedSel;
  assign dirReq = pinSync[2] | tgDirSel;
  assign selLevel = tgSpeedSel ? tgLevel : 2'h0;
  assign absSpd = dsmAbs(actualSpeed);
  assign curLim = s_r.limits[s_r.level];
  assign inhib = s_r.ctrlNeg ? (!actualSpeed[15] && actualSpeed != '0) : actualSpeed[15];

  always_comb begin
    logic [31:0] wv;
    logic viol;
    logic [15:0] lim1;
    logic [15:0] nLim;
    dsm_speed_t sp;
    wv = '0;
    viol = 1'b0;
    lim1 = 16'h0000;
    nLim = 16'h0000;
    sp = '0;
    s_nxt = s_r;
    s_nxt.ackPulse = 1'b0;
    // Register slave, one wait state
    s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
    if (s_nxt.ack && wb_we_i) begin
      if (wb_adr_i[7:4] == `DSM_ADR_LIMIT_HI) begin
        wv = wrMerge({16'h0000, s_r.limits[wb_adr_i[3:2]]}, wb_dat_i, wb_sel_i);
        s_nxt.limits[wb_adr_i[3:2]] = wv[15:0];
      end
      case ({wb_adr_i[7:2], 2'b00})
        `DSM_ADR_CTRL: begin
          wv = wrMerge({28'h0, 1'b0, s_r.ctrlRamp, s_r.ctrlNeg, s_r.ctrlExt}, wb_dat_i, wb_sel_i);
          s_nxt.ctrlExt = wv[`DSM_CTRL_EXT];
          s_nxt.ctrlNeg = wv[`DSM_CTRL_NEG];
          s_nxt.ctrlRamp = wv[`DSM_CTRL_RAMP];
          s_nxt.ackPulse = wv[`DSM_CTRL_ACK];
        end
        `DSM_ADR_STOP_DELAY: begin
          wv = wrMerge({8'h00, s_r.stopDelay}, wb_dat_i, wb_sel_i);
          s_nxt.stopDelay = wv[23:0];
        end
        `DSM_ADR_STOP_SPEED: begin
          wv = wrMerge({16'h0000, s_r.stopSpeed}, wb_dat_i, wb_sel_i);
          s_nxt.stopSpeed = wv[15:0];
        end
        `DSM_ADR_DECEL_STEP: begin
          wv = wrMerge({16'h0000, s_r.decelStep}, wb_dat_i, wb_sel_i);
          s_nxt.decelStep = wv[15:0];
        end
        `DSM_ADR_WINDOW: begin
          wv = wrMerge({8'h00, s_r.window}, wb_dat_i, wb_sel_i);
          s_nxt.window = wv[23:0];
        end
        default: begin
        end
      endcase
    end
    if (s_nxt.ack && !wb_we_i) begin
      if (wb_adr_i[7:4] == `DSM_ADR_LIMIT_HI) begin
        s_nxt.rdat = {16'h0000, s_r.limits[wb_adr_i[3:2]]};
      end else begin
        case ({wb_adr_i[7:2], 2'b00})
          `DSM_ADR_CTRL: s_nxt.rdat = {29'h0, s_r.ctrlRamp, s_r.ctrlNeg, s_r.ctrlExt};
          `DSM_ADR_STOP_DELAY: s_nxt.rdat = {8'h00, s_r.stopDelay};
          `DSM_ADR_STOP_SPEED: s_nxt.rdat = {16'h0000, s_r.stopSpeed};
          `DSM_ADR_DECEL_STEP: s_nxt.rdat = {16'h0000, s_r.decelStep};
          `DSM_ADR_WINDOW: s_nxt.rdat = {8'h00, s_r.window};
          `DSM_ADR_STATUS: s_nxt.rdat = {22'h0, s_r.latched, s_r.level, s_r.dirPh,
                                         s_r.limPh, s_r.st};
          default: s_nxt.rdat = 32'h0000_0000;
        endcase
      end
    end
    // Ramp envelopes shrink once per tick
    if (s_r.tick == 6'(`DSM_RAMP_TICK_CYC - 1)) begin
      s_nxt.tick = 6'h00;
      s_nxt.env = decay(s_r.env, s_r.decelStep);
      s_nxt.dirEnv = decay(s_r.dirEnv, s_r.decelStep);
    end else begin
      s_nxt.tick = 6'(s_r.tick + 6'h01);
    end
    // Guards run only while the drive is in normal operation
    if (s_r.st == DSM_ST_RUN) begin
      case (s_r.limPh)
        DSM_PH_OFF, DSM_PH_ON: begin
          if (!limReq) begin
            s_nxt.limPh = DSM_PH_OFF;
          end else if (s_r.limPh == DSM_PH_OFF || selLevel != s_r.level) begin
            s_nxt.level = selLevel;
            if (absSpd > s_r.limits[selLevel]) begin
              s_nxt.limPh = DSM_PH_ENTRY;
              s_nxt.limTmr = 24'h000000;
              s_nxt.env = absSpd;
            end else begin
              s_nxt.limPh = DSM_PH_ON;
            end
          end else if (absSpd > curLim) begin
            viol = 1'b1;
          end
        end
        DSM_PH_ENTRY: begin
          s_nxt.limTmr = 24'(s_r.limTmr + 24'h000001);
          if (!limReq) begin
            s_nxt.limPh = DSM_PH_OFF;
          end else if (s_r.ctrlRamp) begin
            if (absSpd > s_r.env) begin
              viol = 1'b1;
            end else if (s_r.env <= curLim) begin
              s_nxt.limPh = DSM_PH_ON;
            end
          end else if (s_r.limTmr >= s_r.window) begin
            if (absSpd > curLim) begin
              viol = 1'b1;
            end else begin
              s_nxt.limPh = DSM_PH_ON;
            end
          end
        end
        default: s_nxt.limPh = DSM_PH_OFF;
      endcase
      case (s_r.dirPh)
        DSM_PH_OFF: begin
          if (dirReq) begin
            s_nxt.dirPh = inhib ? DSM_PH_ENTRY : DSM_PH_ON;
            s_nxt.dirTmr = 24'h000000;
            s_nxt.dirEnv = absSpd;
          end
        end
        DSM_PH_ENTRY: begin
          s_nxt.dirTmr = 24'(s_r.dirTmr + 24'h000001);
          if (!dirReq) begin
            s_nxt.dirPh = DSM_PH_OFF;
          end else if (!inhib) begin
            s_nxt.dirPh = DSM_PH_ON;
          end else if (s_r.ctrlRamp ? (absSpd > s_r.dirEnv) : (s_r.dirTmr >= s_r.window)) begin
            viol = 1'b1;
          end
        end
        DSM_PH_ON: begin
          if (!dirReq) begin
            s_nxt.dirPh = DSM_PH_OFF;
          end else if (inhib) begin
            viol = 1'b1;
          end
        end
        default: s_nxt.dirPh = DSM_PH_OFF;
      endcase
    end else begin
      s_nxt.limPh = DSM_PH_OFF;
      s_nxt.dirPh = DSM_PH_OFF;
    end
    // Stop sequencer; a violation outranks a stop request
    case (s_r.st)
      DSM_ST_RUN: begin
        if (viol) begin
          s_nxt.st = DSM_ST_FBRAKE;
        end else if (stopReq) begin
          s_nxt.st = DSM_ST_BRAKE;
          s_nxt.stopTmr = 24'h000000;
          s_nxt.env = absSpd;
        end
      end
      DSM_ST_BRAKE: begin
        s_nxt.stopTmr = 24'(s_r.stopTmr + 24'h000001);
        if (!stopReq) begin
          s_nxt.st = DSM_ST_RUN;
        end else if (s_r.ctrlExt) begin
          if (absSpd > s_r.env) begin
            s_nxt.st = DSM_ST_FBRAKE;
          end else if (absSpd < s_r.stopSpeed) begin
            s_nxt.st = DSM_ST_TOFF;
          end
        end else if (s_r.stopTmr >= s_r.stopDelay) begin
          s_nxt.st = DSM_ST_TOFF;
        end
      end
      DSM_ST_TOFF: begin
        if (!stopReq) begin
          s_nxt.st = DSM_ST_RUN;
        end
      end
      DSM_ST_FBRAKE: begin
        if (absSpd < s_r.stopSpeed) begin
          s_nxt.st = DSM_ST_FTOFF;
        end
      end
      DSM_ST_FTOFF: begin
        if (s_r.ackPulse || tgAck) begin
          s_nxt.st = DSM_ST_RUN;
        end
      end
      default: s_nxt.st = DSM_ST_FTOFF;
    endcase
    // Guards drop out as soon as the drive leaves normal operation
    if (s_nxt.st != DSM_ST_RUN) begin
      s_nxt.limPh = DSM_PH_OFF;
      s_nxt.dirPh = DSM_PH_OFF;
    end
    // Setpoint shaping
    sp = setpointIn;
    if (s_nxt.dirPh != DSM_PH_OFF) begin
      if (s_nxt.ctrlNeg ? (sp > 16'sh0000) : sp[15]) begin
        sp = '0;
      end
    end
    nLim = s_nxt.limits[s_nxt.level];
    lim1 = (nLim == 16'h0000) ? 16'h0000 : 16'(nLim - 16'h0001);
    lim1 = (lim1 > 16'h7fff) ? 16'h7fff : lim1;
    if (s_nxt.limPh != DSM_PH_OFF && dsmAbs(sp) > lim1) begin
      sp = sp[15] ? -dsm_speed_t'(lim1) : dsm_speed_t'(lim1);
    end
    if (s_nxt.st != DSM_ST_RUN) begin
      sp = '0;
    end
    s_nxt.spOut = sp;
    s_nxt.fastRamp = (s_nxt.st == DSM_ST_BRAKE) || (s_nxt.st == DSM_ST_FBRAKE) ||
                     (s_nxt.limPh == DSM_PH_ENTRY) || (s_nxt.dirPh == DSM_PH_ENTRY);
    s_nxt.toff = (s_nxt.st == DSM_ST_TOFF) || (s_nxt.st == DSM_ST_FTOFF);
    s_nxt.stopAct = (s_nxt.st == DSM_ST_BRAKE) || (s_nxt.st == DSM_ST_TOFF);
    s_nxt.limAct = s_nxt.limPh == DSM_PH_ON;
    s_nxt.lvlOut = s_nxt.limAct ? s_nxt.level : 2'h0;
    s_nxt.dirAct = s_nxt.dirPh == DSM_PH_ON;
    s_nxt.latched = (s_nxt.st == DSM_ST_FBRAKE) || (s_nxt.st == DSM_ST_FTOFF);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.stopDelay <= `DSM_STOP_DELAY_RST;
      s_r.stopSpeed <= `DSM_STOP_SPEED_RST;
      s_r.decelStep <= `DSM_DECEL_STEP_RST;
      s_r.limits <= {4{`DSM_LIMIT_RST}};
      s_r.window <= `DSM_WINDOW_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign setpointOut = s_r.spOut;
  assign fastStopRamp = s_r.fastRamp;
  assign torqueRemoval = s_r.toff;
  assign stopActive = s_r.stopAct;
  assign limitActive = s_r.limAct;
  assign levelActive = s_r.lvlOut;
  assign dirActive = s_r.dirAct;
  assign safeStopLatched = s_r.latched;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_toff_no_torque: assert property (
    (s_r.st == DSM_ST_TOFF || s_r.st == DSM_ST_FTOFF) |-> (s_r.toff && s_r.spOut == '0))
    else $error("Torque removal state without torque cut");
  a_fault_held: assert property (
    (s_r.st == DSM_ST_FTOFF && !s_r.ackPulse && !tgAck) |=> (s_r.st == DSM_ST_FTOFF && s_r.toff))
    else $error("Latched safe stop left without acknowledge");
  a_stop_zero_sp: assert property (
    (s_r.st == DSM_ST_BRAKE) |-> (s_r.spOut == '0 && s_r.fastRamp))
    else $error("Controlled stop without zero setpoint");
  a_ext_stop_thresh: assert property (
    (s_r.st == DSM_ST_BRAKE && s_r.ctrlExt && stopReq && absSpd <= s_r.env &&
     absSpd < s_r.stopSpeed) |=> (s_r.st == DSM_ST_TOFF))
    else $error("Extended stop missed speed threshold");
  a_basic_stop_delay: assert property (
    (s_r.st == DSM_ST_BRAKE && !s_r.ctrlExt && stopReq && s_r.stopTmr >= s_r.stopDelay)
    |=> (s_r.st == DSM_ST_TOFF))
    else $error("Basic stop missed delay expiry");
  a_limit_clamp: assert property (
    (s_r.limPh != DSM_PH_OFF && curLim != 16'h0000) |-> (dsmAbs(s_r.spOut) < curLim))
    else $error("Setpoint not below speed limit");
  a_entry_fast_ramp: assert property (
    $rose(s_r.limPh == DSM_PH_ENTRY) |-> s_r.fastRamp)
    else $error("Limit entry without fast-stop ramp");
  a_over_limit_stop: assert property (
    (s_r.st == DSM_ST_RUN && s_r.limPh == DSM_PH_ON && limReq && selLevel == s_r.level &&
     absSpd > curLim) |=> (s_r.st == DSM_ST_FBRAKE && s_r.latched))
    else $error("Overspeed did not trigger safe stop");
  a_dir_clamp_sp: assert property (
    (s_r.dirPh != DSM_PH_OFF) |-> (s_r.ctrlNeg ? (s_r.spOut <= 16'sh0000) : !s_r.spOut[15]))
    else $error("Setpoint in inhibited direction");
  a_dir_violate_stop: assert property (
    (s_r.st == DSM_ST_RUN && s_r.dirPh == DSM_PH_ON && dirReq && inhib)
    |=> (s_r.latched && s_r.fastRamp && s_r.spOut == '0))
    else $error("Inhibited motion did not trigger safe stop");
  a_level_report: assert property (
    (s_r.limPh == DSM_PH_ON) |-> (s_r.limAct && s_r.lvlOut == s_r.level))
    else $error("Active level not reported");

  c_stop_to_toff: cover property (s_r.st == DSM_ST_BRAKE ##1 s_r.st == DSM_ST_TOFF);
  c_limit_entry_on: cover property (s_r.limPh == DSM_PH_ENTRY ##1 s_r.limPh == DSM_PH_ON);
  c_dir_on: cover property ($rose(s_r.dirPh == DSM_PH_ON));
  c_fault_ack: cover property (s_r.st == DSM_ST_FTOFF ##1 s_r.st == DSM_ST_RUN);
endmodule : dsm_motion_monitor

/* logic/dsm_pin_sync.sv */
// Purpose: Two-flop synchroniser for the safety-related select pins
// Assumes: Pins are asynchronous levels
// Notes: First stage feeds only the second
`timescale 1ns/10ps
`include "dsm_consts.svh"
module dsm_pin_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`DSM_PIN_CNT-1:0] pinAsync,
  output logic [`DSM_PIN_CNT-1:0] pinSync
);
  typedef struct packed {
    logic [`DSM_PIN_CNT-1:0] meta;
    logic [`DSM_PIN_CNT-1:0] sync;
  } dsm_sync_state_t;

  dsm_sync_state_t s_r;
  dsm_sync_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = pinAsync;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pinSync = s_r.sync;
endmodule : dsm_pin_sync

/* logic/dsm_pkg.sv */
// Purpose: Types shared by the motion monitor files
// Assumes: Nothing beyond the constants header
// Notes: State encodings are written out
package dsm_pkg;

  typedef logic signed [15:0] dsm_speed_t;

  typedef enum logic [2:0] {
    DSM_ST_RUN = 3'h0,
    DSM_ST_BRAKE = 3'h1,
    DSM_ST_TOFF = 3'h2,
    DSM_ST_FBRAKE = 3'h3,
    DSM_ST_FTOFF = 3'h4
  } dsm_stop_st_t;

  typedef enum logic [1:0] {
    DSM_PH_OFF = 2'h0,
    DSM_PH_ENTRY = 2'h1,
    DSM_PH_ON = 2'h2
  } dsm_phase_t;

endpackage : dsm_pkg

/* verification/dsm_safety_ctrl_model.sv */
// Purpose: Fail-safe controller model driving select pins and telegram
// Assumes: Requests come from the bench on clk_sys
// Notes: Level field wiggles while it carries no valid level
`timescale 1ns/10ps
module dsm_safety_ctrl_model (
  input wire logic clk_sys,
  input wire logic viaPin,
  input wire logic reqStop,
  input wire logic reqSpeed,
  input wire logic reqDir,
  input wire logic [1:0] reqLevel,
  input wire logic reqAck,
  output logic stopSelPin = 1'b0,
  output logic speedSelPin = 1'b0,
  output logic dirSelPin = 1'b0,
  output logic tgStopSel = 1'b0,
  output logic tgSpeedSel = 1'b0,
  output logic [1:0] tgLevel = 2'h0,
  output logic tgDirSel = 1'b0,
  output logic tgAck = 1'b0
);
  always @(posedge clk_sys) begin
    stopSelPin <= reqStop & viaPin;
    speedSelPin <= reqSpeed & viaPin;
    dirSelPin <= reqDir & viaPin;
    tgStopSel <= reqStop & ~viaPin;
    tgSpeedSel <= reqSpeed & ~viaPin;
    tgDirSel <= reqDir & ~viaPin;
    tgLevel <= (reqSpeed & ~viaPin) ? reqLevel : ~tgLevel;
    tgAck <= reqAck;
  end
endmodule : dsm_safety_ctrl_model

/* verification/tb_drive_safe_motion_monitor.sv */
// Purpose: Self-checking bench for the motion monitor
// Assumes: Fixed one wait state on the register bus
// Notes: Delay and window registers are shortened to 10 cycles
`timescale 1ns/10ps
`include "dsm_consts.svh"
module tb_drive_safe_motion_monitor;
  import dsm_pkg::*;
  typedef struct {logic [7:0] adr; logic [31:0] rst; logic [31:0] wr; logic [31:0] exp;} dsm_row_t;
  localparam int STOP = 0, TRQ = 1, LIM = 2, DIR = 3, LAT = 4, FSR = 5;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [3:0] wbSel = 4'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0, wbDatO, rdat;
  logic viaPin = 1'b1, reqStop = 1'b0, reqSpeed = 1'b0, reqDir = 1'b0, reqAck = 1'b0;
  logic [1:0] reqLevel = 2'h0, tLevel, lvlAct;
  logic stopPin, speedPin, dirPin, tStop, tSpeed, tDir, tAck;
  logic fsr, trq, stopAct, limAct, dirAct, latched;
  dsm_speed_t speed = 16'sh0000, spIn = 16'sh0100, spOut;
  int err_count = 0, cmp_count = 0, n;
  logic [15:0] limVal[4] = '{16'h0200, 16'h0100, 16'h0080, 16'h0040};
  dsm_row_t rows[11] = '{
    '{`DSM_ADR_CTRL, 32'h0, 32'h0000000e, 32'h00000006},
    '{`DSM_ADR_STOP_DELAY, `DSM_STOP_DELAY_RST, 32'hff00000a, 32'h0000000a},
    '{`DSM_ADR_STOP_SPEED, `DSM_STOP_SPEED_RST, 32'hffff0020, 32'h00000020},
    '{`DSM_ADR_DECEL_STEP, `DSM_DECEL_STEP_RST, 32'h00000040, 32'h00000040},
    '{8'h10, `DSM_LIMIT_RST, 32'h00000200, 32'h00000200},
    '{8'h14, `DSM_LIMIT_RST, 32'h00000100, 32'h00000100},
    '{8'h18, `DSM_LIMIT_RST, 32'h00000080, 32'h00000080},
    '{8'h1c, `DSM_LIMIT_RST, 32'h00000040, 32'h00000040},
    '{`DSM_ADR_WINDOW, `DSM_WINDOW_RST, 32'h0000000a, 32'h0000000a},
    '{`DSM_ADR_STATUS, 32'h0, 32'hffffffff, 32'h0},
    '{8'h28, 32'h0, 32'hffffffff, 32'h0}};

  always #10 clk_sys = ~clk_sys;

  dsm_safety_ctrl_model partner (.clk_sys(clk_sys), .viaPin(viaPin), .reqStop(reqStop),
    .reqSpeed(reqSpeed), .reqDir(reqDir), .reqLevel(reqLevel), .reqAck(reqAck),
    .stopSelPin(stopPin), .speedSelPin(speedPin), .dirSelPin(dirPin), .tgStopSel(tStop),
    .tgSpeedSel(tSpeed), .tgLevel(tLevel), .tgDirSel(tDir), .tgAck(tAck));

  dsm_motion_monitor dut (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .stopSelPin(stopPin), .speedSelPin(speedPin), .dirSelPin(dirPin),
    .tgStopSel(tStop), .tgSpeedSel(tSpeed), .tgLevel(tLevel), .tgDirSel(tDir), .tgAck(tAck),
    .actualSpeed(speed), .setpointIn(spIn), .setpointOut(spOut), .fastStopRamp(fsr),
    .torqueRemoval(trq), .stopActive(stopAct), .limitActive(limAct), .levelActive(lvlAct),
    .dirActive(dirAct), .safeStopLatched(latched));

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Called just after a rising edge; ends one idle cycle after ack
  task automatic wbCycle(input logic [7:0] a, input logic w, input logic [3:0] s,
                         input logic [31:0] d);
    int k;
    k = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= s;
    wbDat <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wbAck !== 1'b1 && k < 20);
    if (k >= 20) begin
      check("bus ack", 32'h1, 32'h0);
      report_and_stop();
    end
    rdat = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk_sys);
  endtask : wbCycle

  function automatic logic flagOf(input int k);
    case (k)
      STOP: return stopAct;
      TRQ: return trq;
      LIM: return limAct;
      DIR: return dirAct;
      LAT: return latched;
      default: return fsr;
    endcase
  endfunction : flagOf

  // Counts edges until the flag shows the wanted level
  task automatic waitFor(input int k, input logic v, input int lim);
    n = 0;
    while (flagOf(k) !== v) begin
      @(posedge clk_sys);
      n++;
      if (n > lim) begin
        check($sformatf("wait flag %0d", k), 32'(v), 32'(flagOf(k)));
        report_and_stop();
      end
    end
  endtask : waitFor

  initial begin
    repeat (20) @(posedge clk_sys);
    check("outs rst", 32'h0, {spOut, fsr, trq, stopAct, limAct, lvlAct, dirAct, latched, wbAck});
    nrst <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      wbCycle(rows[i].adr, 1'b0, 4'hf, 32'h0);
      check($sformatf("reg %h rst", rows[i].adr), rows[i].rst, rdat);
      wbCycle(rows[i].adr, 1'b1, 4'hf, rows[i].wr);
      wbCycle(rows[i].adr, 1'b0, 4'hf, 32'h0);
      check($sformatf("reg %h rw", rows[i].adr), rows[i].exp, rdat);
    end
    wbCycle(8'h10, 1'b1, 4'h2, 32'h00001234);
    wbCycle(8'h10, 1'b0, 4'hf, 32'h0);
    check("sel merge", 32'h00001200, rdat);
    wbCycle(8'h10, 1'b1, 4'hf, 32'h00000200);
    wbCycle(`DSM_ADR_CTRL, 1'b1, 4'hf, 32'h0);
    // Basic stop over the telegram
    viaPin <= 1'b0;
    speed <= 16'sh0300;
    spIn <= 16'sh0500;
    reqStop <= 1'b1;
    waitFor(STOP, 1'b1, 10);
    check("stop sp", 32'h0, spOut);
    check("stop fsr", 32'h1, fsr);
    waitFor(TRQ, 1'b1, 100);
    check("stop delay", 32'h0000000b, n);
    check("toff fsr", 32'h0, fsr);
    reqStop <= 1'b0;
    waitFor(STOP, 1'b0, 10);
    // Extended stop over a pin, deceleration too slow
    wbCycle(`DSM_ADR_CTRL, 1'b1, 4'hf, 32'h1);
    viaPin <= 1'b1;
    speed <= 16'sh0100;
    reqStop <= 1'b1;
    waitFor(LAT, 1'b1, 200);
    check("ext trq", 32'h0, trq);
    check("ext fsr", 32'h1, fsr);
    speed <= 16'sh0000;
    waitFor(TRQ, 1'b1, 10);
    reqStop <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check("latch hold", 32'h1, latched);
    wbCycle(`DSM_ADR_CTRL, 1'b1, 4'hf, 32'h9);
    waitFor(LAT, 1'b0, 10);
    speed <= 16'sh0100;
    reqStop <= 1'b1;
    waitFor(STOP, 1'b1, 10);
    speed <= 16'sh0010;
    waitFor(TRQ, 1'b1, 10);
    check("ext ok", 32'h0, latched);
    reqStop <= 1'b0;
    waitFor(STOP, 1'b0, 10);
    wbCycle(`DSM_ADR_CTRL, 1'b1, 4'hf, 32'h0);
    // Limited speed: pin gives level zero whatever the telegram shows
    speed <= -16'sh0030;
    spIn <= 16'sh7000;
    reqLevel <= 2'h3;
    reqSpeed <= 1'b1;
    waitFor(LIM, 1'b1, 100);
    check("pin lvl", 32'h0, lvlAct);
    check("pin clamp", 32'h000001ff, spOut);
    viaPin <= 1'b0;
    for (int lv = 0; lv < 4; lv++) begin
      reqLevel <= 2'(lv);
      repeat (4) @(posedge clk_sys);
      waitFor(LIM, 1'b1, 100);
      check("lvl", 32'(lv), lvlAct);
      check("lvl clamp", 32'(limVal[lv] - 16'h0001), spOut);
    end
    speed <= -16'sh0041;
    waitFor(LAT, 1'b1, 5);
    check("ovr lim", 32'h0, limAct);
    check("ovr fsr", 32'h1, fsr);
    speed <= 16'sh0000;
    waitFor(TRQ, 1'b1, 10);
    speed <= 16'sh0080;
    reqAck <= 1'b1;
    waitFor(LAT, 1'b0, 10);
    reqAck <= 1'b0;
    waitFor(FSR, 1'b1, 10);
    check("entry lim", 32'h0, limAct);
    speed <= 16'sh0020;
    waitFor(LIM, 1'b1, 30);
    check("entry ok", 32'h0, latched);
    reqSpeed <= 1'b0;
    waitFor(LIM, 1'b0, 10);
    // Direction guard, positive direction permitted
    viaPin <= 1'b1;
    speed <= 16'sh0050;
    spIn <= -16'sh0100;
    reqDir <= 1'b1;
    waitFor(DIR, 1'b1, 30);
    check("dir sp", 32'h0, spOut);
    spIn <= 16'sh0100;
    repeat (3) @(posedge clk_sys);
    check("dir pass", 32'h00000100, spOut);
    viaPin <= 1'b0;
    speed <= -16'sh0010;
    waitFor(LAT, 1'b1, 10);
    check("dir fsr", 32'h1, fsr);
    check("dir off", 32'h0, dirAct);
    speed <= 16'sh0000;
    waitFor(TRQ, 1'b1, 10);
    speed <= -16'sh0010;
    wbCycle(`DSM_ADR_CTRL, 1'b1, 4'hf, 32'h8);
    waitFor(LAT, 1'b0, 10);
    waitFor(FSR, 1'b1, 10);
    speed <= 16'sh0000;
    waitFor(DIR, 1'b1, 30);
    check("dir ok", 32'h0, latched);
    reqDir <= 1'b0;
    waitFor(DIR, 1'b0, 10);
    // Ramp mode, negative direction permitted, motion fades too slowly
    wbCycle(`DSM_ADR_CTRL, 1'b1, 4'hf, 32'h6);
    speed <= 16'sh0100;
    reqDir <= 1'b1;
    waitFor(FSR, 1'b1, 10);
    check("neg sp", 32'h0, spOut);
    waitFor(LAT, 1'b1, 100);
    check("neg dir", 32'h0, dirAct);
    // Reset in mid-run clears state and reloads the configuration reset values
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    check("outs rst2", 32'h0, {spOut, fsr, trq, stopAct, limAct, lvlAct, dirAct, latched, wbAck});
    wbCycle(`DSM_ADR_CTRL, 1'b0, 4'hf, 32'h0);
    check("ctrl rst2", 32'h0, rdat);
    report_and_stop();
  end
endmodule : tb_drive_safe_motion_monitor
